// ---- src/nhp_pkg.sv ----
/*
 nhp_pkg: shared constants and carriers for the host port of the network
 adapter: register offsets, command and field bits, frame size limits,
 queue depths and the packed structs for status entries and the bus.
 assumes: included before any module of the block; no clock or reset here.
*/
`default_nettype none
package nhp_pkg;
	////////////////////////////////////////////////////////////////////////
	// register bus
	localparam int unsigned NHP_AW = 8; // byte address width
	localparam logic [7:0] NHP_OFF_CMD = 8'h00; // command strobes
	localparam logic [7:0] NHP_OFF_CAUSE = 8'h04; // interrupt_cause_register
	localparam logic [7:0] NHP_OFF_MASK = 8'h08; // interrupt mask
	localparam logic [7:0] NHP_OFF_TXRES = 8'h0C; // tx_result_register
	localparam logic [7:0] NHP_OFF_TXLVL = 8'h10; // tx_early_start_level
	localparam logic [7:0] NHP_OFF_MEDIA = 8'h14; // media_state_register
	localparam logic [7:0] NHP_OFF_MAC = 8'h18; // mac_config_register
	localparam logic [7:0] NHP_OFF_RXTOP = 8'h1C; // rx_top_status
	localparam logic [7:0] NHP_OFF_RXFLT = 8'h20; // rx_fault_register
	localparam logic [7:0] NHP_OFF_WIN = 8'h24; // rx_fifo_window
	localparam logic [7:0] NHP_OFF_DPTR = 8'h28; // dma_buffer_pointer
	localparam logic [7:0] NHP_OFF_DCNT = 8'h2C; // dma_byte_count
	localparam logic [7:0] NHP_OFF_DSTA = 8'h30; // dma_state_register
	// command bits
	localparam int unsigned NHP_CMD_TX_EN = 0; // re-enable transmitter
	localparam int unsigned NHP_CMD_TX_RST = 1; // tx_logic_reset_cmd
	localparam int unsigned NHP_CMD_RX_DROP = 2; // rx_drop_top_cmd
	localparam int unsigned NHP_CMD_DMA_GO = 3; // dma_go_cmd
	// cause and mask bits
	localparam int unsigned NHP_CAU_TX = 0; // tx_done_flag
	localparam int unsigned NHP_CAU_RX = 1; // rx_frame_done_flag
	localparam int unsigned NHP_CAU_DMA = 2; // dma upload done
	// mac config bits
	localparam int unsigned NHP_MAC_BIG = 0; // big_frame_allow
	localparam int unsigned NHP_MAC_FCS = 1; // keep fcs in rx data
	localparam logic [1:0] NHP_MAC_RST = 2'h0;
	////////////////////////////////////////////////////////////////////////
	// frame sizes in bytes
	localparam logic [12:0] NHP_TRUNC_STD = 13'h0700; // 1792
	localparam logic [12:0] NHP_TRUNC_BIG = 13'h1800; // 6144
	localparam logic [12:0] NHP_LONG_STD = 13'h05EE; // 1518
	localparam logic [12:0] NHP_LONG_BIG = 13'h118E; // 4494
	localparam logic [12:0] NHP_RUNT = 13'h0040; // 64, fcs included
	localparam logic [12:0] NHP_LVL_RST = 13'h1FFF; // early start off
	// storage
	localparam int unsigned NHP_RX_AW = 13; // 8192 byte receive store
	localparam int unsigned NHP_Q_AW = 2; // four entries per queue
	localparam logic [NHP_RX_AW:0] NHP_RX_DEPTH = 14'h2000;
	localparam logic [NHP_Q_AW:0] NHP_Q_DEPTH = 3'h4;
	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [NHP_AW-1:0] addr; // byte address
		logic [31:0] wdata; // write data
		logic [3:0] be; // byte lanes of a window read
		logic wr; // write strobe
		logic rd; // read strobe
	} nhp_bus_t;
	typedef struct packed {
		logic requested; // tx_status_request_flag of the frame
		logic error; // any transmit error
		logic starved; // tx_starved_flag
		logic [3:0] code; // transmitter error code
	} nhp_txstat_t;
	typedef struct packed {
		logic overrun;
		logic framing;
		logic crc;
		logic oversize; // frame_too_long_error
		logic runt;
	} nhp_rxerr_t;
	typedef struct packed {
		logic [12:0] len; // stored bytes
		nhp_rxerr_t err;
	} nhp_rxdesc_t;
endpackage : nhp_pkg
`default_nettype wire

// ---- src/nhp_host_port.sv ----
/*
 nhp_host_port: host side of the adapter: transmit status queue, early
 start and starvation handling, receive store with top frame status,
 window reads, drop command, paced upload engine and size limits.
 assumes: one 200 MHz clock; transmitter, receiver and upload sink are
 synchronous logic on the same clock; host bus as a simple strobe port.
*/
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module nhp_host_port
(
	input wire logic sys_clk_i, // 200 MHz
	input wire logic sys_rst_i, // async, active high
	input wire nhp_pkg::nhp_bus_t bus_i, // register access
	output logic [31:0] bus_rdata_o, // valid the cycle after rd
	output logic host_irq_o, // interrupt to host bus
	input wire logic tx_attempt_done_i, // attempts for a frame ended
	input wire logic tx_status_req_i, // frame asked for status
	input wire logic tx_err_i, // attempt ended in error
	input wire logic [3:0] tx_err_code_i, // error detail
	input wire logic [12:0] tx_bytes_held_i, // bytes of frame on chip
	input wire logic tx_frame_whole_i, // whole frame on chip
	input wire logic tx_sending_i, // frame on the wire
	input wire logic tx_data_empty_i, // transmit data ran out
	output logic tx_start_ok_o, // transmitter may start
	output logic tx_bad_crc_o, // end frame with bad crc
	output logic tx_logic_reset_o, // reset transmit logic
	input wire logic rx_byte_valid_i, // received byte
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_byte_is_fcs_i, // byte belongs to fcs
	input wire logic rx_frame_end_i, // frame ended, after last byte
	input wire logic rx_crc_bad_i, // with frame end
	input wire logic rx_framing_bad_i, // with frame end
	output logic dma_valid_o, // upload byte offered
	output logic [31:0] dma_addr_o,
	output logic [7:0] dma_data_o,
	input wire logic dma_ready_i // upload sink takes byte
);
	import nhp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state
	typedef enum logic {NHP_DMA_IDLE, NHP_DMA_RUN} nhp_dma_st_t;
	logic [7:0] rx_mem [0:(1<<NHP_RX_AW)-1]; // receive byte store
	nhp_txstat_t txq_r [0:(1<<NHP_Q_AW)-1]; // transmit status queue
	nhp_rxdesc_t rxq_r [0:(1<<NHP_Q_AW)-1]; // complete frame queue
	logic [NHP_Q_AW-1:0] txq_rd_r, txq_rd_nxt, txq_wr_r, txq_wr_nxt;
	logic [NHP_Q_AW:0] txq_cnt_r, txq_cnt_nxt;
	logic tx_halt_r, tx_halt_nxt; // transmit stopped by error
	logic starve_r, starve_nxt; // starvation seen this frame
	logic tx_bad_crc_r, tx_bad_crc_nxt;
	logic tx_rst_r, tx_rst_nxt;
	logic [12:0] lvl_r, lvl_nxt; // tx_early_start_level
	logic [1:0] mac_r, mac_nxt; // mac_config_register
	logic [2:0] mask_r, mask_nxt; // interrupt mask
	logic rx_done_r, rx_done_nxt; // rx_frame_done_flag
	logic dma_done_r, dma_done_nxt; // dma_upload_done
	logic irq_r, irq_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [NHP_RX_AW:0] wp_r, wp_nxt, rp_r, rp_nxt; // byte pointers
	logic [NHP_Q_AW-1:0] rxq_rd_r, rxq_rd_nxt, rxq_wr_r, rxq_wr_nxt;
	logic [NHP_Q_AW:0] rxq_cnt_r, rxq_cnt_nxt; // complete frames
	logic [12:0] cur_len_r, cur_len_nxt; // stored bytes of new frame
	logic [12:0] raw_r, raw_nxt; // wire bytes incl fcs
	logic ovr_r, ovr_nxt; // overrun in new frame
	logic skip_r, skip_nxt; // new frame dropped
	logic [12:0] used_r, used_nxt; // top bytes already read
	nhp_dma_st_t dst_r, dst_nxt;
	logic [31:0] dptr_r, dptr_nxt, dcnt_r, dcnt_nxt;
	logic dval_r, dval_nxt;
	logic [7:0] ddat_r, ddat_nxt;
	logic [31:0] daddr_r, daddr_nxt;
	// decoded strobes and derived terms
	logic wr_cmd, wr_txres, rd_win, tx_push, tx_pop, rx_store, rx_commit;
	logic drop, drop_q, new_slot;
	logic [12:0] trunc_lim, long_lim, top_len, left, pop_n;
	nhp_rxdesc_t top_desc;
	nhp_txstat_t tx_ent;
	logic [31:0] win_data;
	logic [2:0] cause;

	////////////////////////////////////////////////////////////////////////
	// decode and derived values
	always_comb
	begin
		wr_cmd = bus_i.wr && bus_i.addr == NHP_OFF_CMD;
		wr_txres = bus_i.wr && bus_i.addr == NHP_OFF_TXRES;
		rd_win = bus_i.rd && bus_i.addr == NHP_OFF_WIN;
		// size limits follow big frame option
		trunc_lim = mac_r[NHP_MAC_BIG] ? NHP_TRUNC_BIG : NHP_TRUNC_STD;
		long_lim = mac_r[NHP_MAC_BIG] ? NHP_LONG_BIG : NHP_LONG_STD;
		// oldest frame is top, else the arriving one
		top_desc = rxq_r[rxq_rd_r];
		top_len = (rxq_cnt_r != '0) ? top_desc.len : cur_len_r;
		left = top_len - used_r;
		// status entry posted on error or request
		tx_ent.requested = tx_status_req_i;
		tx_ent.error = tx_err_i || starve_r;
		tx_ent.starved = starve_r;
		tx_ent.code = tx_err_code_i;
		tx_push = tx_attempt_done_i && txq_cnt_r != NHP_Q_DEPTH
			&& (tx_status_req_i || tx_ent.error);
		tx_pop = wr_txres && txq_cnt_r != '0;
		drop = wr_cmd && bus_i.wdata[NHP_CMD_RX_DROP];
		drop_q = drop && rxq_cnt_r != '0;
		new_slot = rxq_cnt_r != NHP_Q_DEPTH;
		rx_store = rx_byte_valid_i && !skip_r && new_slot
			&& (!rx_byte_is_fcs_i || mac_r[NHP_MAC_FCS])
			&& raw_r < trunc_lim
			&& (wp_r - rp_r) != NHP_RX_DEPTH;
		rx_commit = rx_frame_end_i && !skip_r && new_slot && raw_r != '0;
		cause = {dma_done_r, rx_done_r, txq_cnt_r != '0};
	end

	////////////////////////////////////////////////////////////////////////
	// window read: lanes filled in order from the lowest enabled lane
	always_comb
	begin
		logic [2:0] n;
		logic [1:0] k;
		n = '0;
		k = '0;
		win_data = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (bus_i.be[i])
			begin
				win_data[8*i +: 8] = rx_mem[rp_r[NHP_RX_AW-1:0]
					+ NHP_RX_AW'(k)];
				k = k + 2'h1;
				n = n + 3'h1;
			end
		end
		// clamp so extra bytes past the end never eat the next frame
		pop_n = 13'(n) > left ? left : 13'(n);
	end

	////////////////////////////////////////////////////////////////////////
	// transmit next values
	always_comb
	begin
		txq_wr_nxt = txq_wr_r + NHP_Q_AW'(tx_push);
		txq_rd_nxt = txq_rd_r + NHP_Q_AW'(tx_pop);
		txq_cnt_nxt = txq_cnt_r + (NHP_Q_AW+1)'(tx_push)
			- (NHP_Q_AW+1)'(tx_pop);
		tx_halt_nxt = tx_halt_r;
		tx_rst_nxt = wr_cmd && bus_i.wdata[NHP_CMD_TX_RST];
		if (wr_cmd && (bus_i.wdata[NHP_CMD_TX_EN]
			|| bus_i.wdata[NHP_CMD_TX_RST]))
		begin
			tx_halt_nxt = 1'b0; // host recovery
		end
		if (tx_attempt_done_i && tx_ent.error)
		begin
			tx_halt_nxt = 1'b1;
		end
		// data ran dry on the wire
		tx_bad_crc_nxt = tx_sending_i && tx_data_empty_i
			&& !tx_frame_whole_i && !starve_r;
		starve_nxt = starve_r;
		if (tx_bad_crc_nxt)
		begin
			starve_nxt = 1'b1;
		end
		else if (tx_attempt_done_i || tx_rst_nxt)
		begin
			starve_nxt = 1'b0;
		end
		lvl_nxt = (bus_i.wr && bus_i.addr == NHP_OFF_TXLVL)
			? bus_i.wdata[12:0] : lvl_r;
	end

	////////////////////////////////////////////////////////////////////////
	// receive next values
	always_comb
	begin
		wp_nxt = wp_r + (NHP_RX_AW+1)'(rx_store);
		cur_len_nxt = cur_len_r + 13'(rx_store);
		raw_nxt = raw_r + 13'(rx_byte_valid_i && raw_r < trunc_lim);
		ovr_nxt = ovr_r || (rx_byte_valid_i && !skip_r && !rx_store
			&& raw_r < trunc_lim
			&& (!rx_byte_is_fcs_i || mac_r[NHP_MAC_FCS]));
		skip_nxt = skip_r;
		rxq_wr_nxt = rxq_wr_r + NHP_Q_AW'(rx_commit);
		rxq_rd_nxt = rxq_rd_r + NHP_Q_AW'(drop_q);
		rxq_cnt_nxt = rxq_cnt_r + (NHP_Q_AW+1)'(rx_commit)
			- (NHP_Q_AW+1)'(drop_q);
		rp_nxt = rp_r;
		used_nxt = used_r;
		if (rx_frame_end_i)
		begin
			cur_len_nxt = '0;
			raw_nxt = '0;
			ovr_nxt = 1'b0;
			skip_nxt = 1'b0;
		end
		if (drop_q)
		begin
			// jump over what is left of the top frame
			rp_nxt = rp_r + (NHP_RX_AW+1)'(left);
			used_nxt = '0;
		end
		else if (drop && !rx_frame_end_i && raw_r != '0)
		begin
			// top still arriving: throw away the rest of it
			skip_nxt = 1'b1;
			rp_nxt = wp_r;
			used_nxt = '0;
			cur_len_nxt = '0;
			wp_nxt = wp_r;
		end
		else if (rd_win && dst_r == NHP_DMA_IDLE)
		begin
			rp_nxt = rp_r + (NHP_RX_AW+1)'(pop_n);
			used_nxt = used_r + pop_n;
		end
		else if (dval_nxt && (!dval_r || dma_ready_i) && dst_r == NHP_DMA_RUN)
		begin
			rp_nxt = rp_r + (NHP_RX_AW+1)'(1);
			used_nxt = used_r + 13'h0001;
		end
		// set wins over the drop clear
		rx_done_nxt = rx_done_r && !drop;
		if (rx_commit || (drop_q && rxq_cnt_r > 1))
		begin
			rx_done_nxt = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// upload engine and register writes
	always_comb
	begin
		dst_nxt = dst_r;
		dptr_nxt = dptr_r;
		dcnt_nxt = dcnt_r;
		dval_nxt = dval_r;
		ddat_nxt = ddat_r;
		daddr_nxt = daddr_r;
		dma_done_nxt = dma_done_r;
		if (bus_i.wr && bus_i.addr == NHP_OFF_DSTA && bus_i.wdata[0])
		begin
			dma_done_nxt = 1'b0; // write one to clear
		end
		if (bus_i.wr && bus_i.addr == NHP_OFF_DPTR)
		begin
			dptr_nxt = bus_i.wdata;
		end
		if (bus_i.wr && bus_i.addr == NHP_OFF_DCNT)
		begin
			dcnt_nxt = bus_i.wdata;
		end
		unique case (dst_r)
			NHP_DMA_IDLE:
			begin
				if (wr_cmd && bus_i.wdata[NHP_CMD_DMA_GO])
				begin
					dst_nxt = NHP_DMA_RUN;
				end
			end
			NHP_DMA_RUN:
			begin
				if (!dval_r || dma_ready_i)
				begin
					// offer a byte only when the top frame has one
					if (dcnt_r != '0 && left != '0)
					begin
						dval_nxt = 1'b1;
						ddat_nxt = rx_mem[rp_r[NHP_RX_AW-1:0]];
						daddr_nxt = dptr_r;
						dptr_nxt = dptr_r + 32'h1;
						dcnt_nxt = dcnt_r - 32'h1;
					end
					else
					begin
						dval_nxt = 1'b0;
						if (dcnt_r == '0)
						begin
							dst_nxt = NHP_DMA_IDLE;
							dma_done_nxt = 1'b1;
						end
					end
				end
			end
		endcase
		mac_nxt = (bus_i.wr && bus_i.addr == NHP_OFF_MAC)
			? bus_i.wdata[1:0] : mac_r;
		mask_nxt = (bus_i.wr && bus_i.addr == NHP_OFF_MASK)
			? bus_i.wdata[2:0] : mask_r;
		irq_nxt = |(cause & mask_r);
	end

	////////////////////////////////////////////////////////////////////////
	// read data mux, answered in the following cycle
	always_comb
	begin
		rdata_nxt = '0;
		if (bus_i.rd)
		begin
			unique case (bus_i.addr)
				NHP_OFF_CAUSE: rdata_nxt = {29'h0, cause};
				NHP_OFF_MASK: rdata_nxt = {29'h0, mask_r};
				NHP_OFF_TXRES: rdata_nxt = {25'h0, txq_r[txq_rd_r]};
				NHP_OFF_TXLVL: rdata_nxt = {19'h0, lvl_r};
				NHP_OFF_MEDIA: rdata_nxt = {30'h0, tx_halt_r, tx_sending_i};
				NHP_OFF_MAC: rdata_nxt = {30'h0, mac_r};
				NHP_OFF_RXTOP: rdata_nxt = {17'h0, rxq_cnt_r == '0,
					|top_desc.err && rxq_cnt_r != '0, left};
				NHP_OFF_RXFLT: rdata_nxt = {27'h0, (rxq_cnt_r != '0)
					? top_desc.err : 5'h00};
				NHP_OFF_WIN: rdata_nxt = win_data;
				NHP_OFF_DPTR: rdata_nxt = dptr_r;
				NHP_OFF_DCNT: rdata_nxt = dcnt_r;
				NHP_OFF_DSTA: rdata_nxt = {30'h0, dst_r == NHP_DMA_RUN,
					dma_done_r};
				default: rdata_nxt = '0; // unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// storage writes: byte store and both queues
	always_ff @(posedge sys_clk_i)
	begin
		if (rx_store)
		begin
			rx_mem[wp_r[NHP_RX_AW-1:0]] <= rx_byte_i;
		end
		if (tx_push)
		begin
			txq_r[txq_wr_r] <= tx_ent;
		end
		if (rx_commit)
		begin
			rxq_r[rxq_wr_r] <= {cur_len_r, ovr_r, rx_framing_bad_i,
				rx_crc_bad_i, raw_r > long_lim,
				raw_r < NHP_RUNT};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			txq_rd_r <= '0; txq_wr_r <= '0; txq_cnt_r <= '0;
			tx_halt_r <= 1'b0; starve_r <= 1'b0; tx_bad_crc_r <= 1'b0;
			tx_rst_r <= 1'b0; lvl_r <= NHP_LVL_RST; mac_r <= NHP_MAC_RST;
			mask_r <= '0; rx_done_r <= 1'b0; dma_done_r <= 1'b0;
			irq_r <= 1'b0; rdata_r <= '0; wp_r <= '0; rp_r <= '0;
			rxq_rd_r <= '0; rxq_wr_r <= '0; rxq_cnt_r <= '0;
			cur_len_r <= '0; raw_r <= '0; ovr_r <= 1'b0; skip_r <= 1'b0;
			used_r <= '0; dst_r <= NHP_DMA_IDLE; dptr_r <= '0;
			dcnt_r <= '0; dval_r <= 1'b0; ddat_r <= '0; daddr_r <= '0;
		end
		else
		begin
			txq_rd_r <= txq_rd_nxt; txq_wr_r <= txq_wr_nxt;
			txq_cnt_r <= txq_cnt_nxt; tx_halt_r <= tx_halt_nxt;
			starve_r <= starve_nxt; tx_bad_crc_r <= tx_bad_crc_nxt;
			tx_rst_r <= tx_rst_nxt; lvl_r <= lvl_nxt; mac_r <= mac_nxt;
			mask_r <= mask_nxt; rx_done_r <= rx_done_nxt;
			dma_done_r <= dma_done_nxt; irq_r <= irq_nxt;
			rdata_r <= rdata_nxt; wp_r <= wp_nxt; rp_r <= rp_nxt;
			rxq_rd_r <= rxq_rd_nxt; rxq_wr_r <= rxq_wr_nxt;
			rxq_cnt_r <= rxq_cnt_nxt; cur_len_r <= cur_len_nxt;
			raw_r <= raw_nxt; ovr_r <= ovr_nxt; skip_r <= skip_nxt;
			used_r <= used_nxt; dst_r <= dst_nxt; dptr_r <= dptr_nxt;
			dcnt_r <= dcnt_nxt; dval_r <= dval_nxt; ddat_r <= ddat_nxt;
			daddr_r <= daddr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	// early start unless level is above the longest frame
	assign tx_start_ok_o = !tx_halt_r && (lvl_r > long_lim
		? tx_frame_whole_i
		: (tx_frame_whole_i || tx_bytes_held_i >= lvl_r));
	assign tx_bad_crc_o = tx_bad_crc_r;
	assign tx_logic_reset_o = tx_rst_r;
	assign bus_rdata_o = rdata_r;
	assign host_irq_o = irq_r;
	assign dma_valid_o = dval_r;
	assign dma_data_o = ddat_r;
	assign dma_addr_o = daddr_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_tx_post_gate: assert property (tx_attempt_done_i && !tx_status_req_i
		&& !tx_err_i && !starve_r |=> txq_cnt_r == $past(txq_cnt_r)
		- (NHP_Q_AW+1)'($past(tx_pop)))
		else $error("status posted without cause");
	a_tx_err_halt: assert property (tx_attempt_done_i && tx_err_i
		&& txq_cnt_r != NHP_Q_DEPTH |=> tx_halt_r && !tx_start_ok_o
		&& cause[NHP_CAU_TX])
		else $error("tx error did not halt");
	a_tx_advance: assert property (wr_txres && txq_cnt_r == 3'h1
		&& !tx_push |=> cause[NHP_CAU_TX] == 1'b0)
		else $error("tx done stuck");
	a_tx_keep: assert property (wr_txres && txq_cnt_r > 3'h1
		|=> cause[NHP_CAU_TX] && txq_rd_r == $past(txq_rd_r) + 2'h1)
		else $error("tx queue not advanced");
	a_early_level: assert property (tx_start_ok_o && !tx_frame_whole_i
		|-> tx_bytes_held_i >= lvl_r && lvl_r <= long_lim)
		else $error("early start too soon");
	a_starve_crc: assert property (tx_sending_i && tx_data_empty_i
		&& !tx_frame_whole_i && !starve_r |=> tx_bad_crc_o ##1 !tx_bad_crc_o)
		else $error("no bad crc on starve");
	a_rx_done_set: assert property (rx_commit |=> rx_done_r)
		else $error("frame done not set");
	a_drop_promote: assert property (drop_q && rxq_cnt_r > 3'h1
		&& !rx_commit |=> rx_done_r && rxq_cnt_r == $past(rxq_cnt_r) - 3'h1)
		else $error("drop did not promote");
	a_trunc_len: assert property (cur_len_r <= trunc_lim)
		else $error("frame above truncation");
	a_dma_pace: assert property (dval_r && dma_ready_i && dst_r
		== NHP_DMA_RUN && dcnt_r == '0 ##1 !dval_r |-> ##[0:1] dma_done_r)
		else $error("upload end not flagged");
	c_tx_err: cover property (tx_attempt_done_i && tx_err_i);
	c_rx_drop: cover property (drop_q && rxq_cnt_r > 3'h1);
	c_dma_end: cover property ($rose(dma_done_r));
	c_win_rd: cover property (rd_win && bus_i.be == 4'hF && left > 13'h3);
endmodule : nhp_host_port
`default_nettype wire

// ---- test/nhp_net_model.sv ----
/*
 nhp_net_model: medium side receiver feeding frames, plus upload sink.
 assumes: shares the host port clock; frames are started by bench calls.
*/
`timescale 1ns/100ps
`default_nettype none
module nhp_net_model
(
	input wire logic clk_i, // host port clock
	input wire logic slow_i, // sink stalls every other cycle
	output logic vld_o, // received byte valid
	output logic [7:0] byte_o, // received byte
	output logic fcs_o, // byte belongs to fcs
	output logic end_o, // frame end, after last byte
	output logic rdy_o // upload sink ready
);
	logic phase; // stall pattern
	initial
	begin
		vld_o = 1'b0;
		byte_o = 8'hA5;
		fcs_o = 1'b0;
		end_o = 1'b0;
		phase = 1'b0;
	end
	// sink answers promptly or slowly
	always @(posedge clk_i)
		phase <= ~phase;
	assign rdy_o = ~slow_i | phase;
	// one frame, byte k = 10h+k, last four bytes are fcs
	task automatic send(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(posedge clk_i);
			vld_o <= 1'b1;
			byte_o <= 8'h10 + k[7:0];
			fcs_o <= (k >= n - 4);
		end
		@(posedge clk_i);
		vld_o <= 1'b0;
		byte_o <= ~byte_o; // released line no longer shows data
		end_o <= 1'b1;
		@(posedge clk_i);
		end_o <= 1'b0;
	endtask : send
endmodule : nhp_net_model
`default_nettype wire

// ---- test/tb_nhp_host_port.sv ----
/*
 tb_nhp_host_port: register level tests of the host port.
 assumes: package nhp_pkg and the net model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_nhp_host_port;
	import nhp_pkg::*;
	logic clk = 0, rst = 1, done = 0, req = 0, err = 0, whole = 0, snd = 0;
	logic emp = 0, slow = 1, vld, fcs, fe, rdy, irq, sok, bcrc, trst, dv;
	logic crcb = 0; // crc fault reported with frame end
	logic [7:0] rb, dd;
	logic [12:0] held = 0;
	logic [3:0] ecode = 0; // transmitter error detail
	logic [31:0] rd, da, v;
	nhp_bus_t b = '0;
	int fails = 0, comparisons = 0;
	nhp_net_model net (.clk_i(clk), .slow_i(slow), .vld_o(vld), .byte_o(rb),
		.fcs_o(fcs), .end_o(fe), .rdy_o(rdy));
	nhp_host_port uut (.sys_clk_i(clk), .sys_rst_i(rst), .bus_i(b),
		.bus_rdata_o(rd), .host_irq_o(irq), .tx_attempt_done_i(done),
		.tx_status_req_i(req), .tx_err_i(err), .tx_err_code_i(ecode),
		.tx_bytes_held_i(held), .tx_frame_whole_i(whole),
		.tx_sending_i(snd), .tx_data_empty_i(emp), .tx_start_ok_o(sok),
		.tx_bad_crc_o(bcrc), .tx_logic_reset_o(trst), .rx_byte_valid_i(vld),
		.rx_byte_i(rb), .rx_byte_is_fcs_i(fcs), .rx_frame_end_i(fe),
		.rx_crc_bad_i(crcb), .rx_framing_bad_i(1'b0), .dma_valid_o(dv),
		.dma_addr_o(da), .dma_data_o(dd), .dma_ready_i(rdy));
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		b.wr <= 1'b1; b.addr <= a; b.wdata <= d;
		@(posedge clk);
		b.wr <= 1'b0;
	endtask : wr
	task automatic rdm(input logic [7:0] a, input logic [31:0] m);
		@(posedge clk);
		b.rd <= 1'b1; b.addr <= a; b.be <= 4'hF;
		@(posedge clk);
		b.rd <= 1'b0;
		#1 v = rd & m;
	endtask : rdm
	task automatic att(input logic q, e);
		@(posedge clk);
		done <= 1'b1; req <= q; err <= e;
		@(posedge clk);
		done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : att
	task automatic summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// watchdog well beyond the expected run
	initial
	begin
		#100000;
		fails++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdm(NHP_OFF_TXLVL, 32'hFFFF); chk("level", v, 32'h1FFF);
		att(0, 0); rdm(NHP_OFF_CAUSE, 1); chk("nopost", v, 0);
		wr(NHP_OFF_MASK, 1); att(1, 0); att(1, 0);
		rdm(NHP_OFF_CAUSE, 1); chk("txdone", v, 1);
		chk("irq", irq, 1);
		rdm(NHP_OFF_TXRES, 32'h7F); chk("txres", v, 32'h40);
		wr(NHP_OFF_TXRES, 0); rdm(NHP_OFF_CAUSE, 1); chk("hold", v, 1);
		wr(NHP_OFF_TXRES, 0); rdm(NHP_OFF_CAUSE, 1); chk("clr", v, 0);
		whole <= 1'b1; ecode <= 4'h5; att(0, 1);
		#1 chk("halt", sok, 0);
		rdm(NHP_OFF_TXRES, 32'h7F); chk("errres", v, 32'h25);
		wr(NHP_OFF_TXRES, 0); wr(NHP_OFF_CMD, 1);
		wr(NHP_OFF_TXLVL, 32'h64); whole <= 1'b0; held <= 13'h63;
		@(posedge clk); #1 chk("early0", sok, 0);
		held <= 13'h64; @(posedge clk); #1 chk("early1", sok, 1);
		wr(NHP_OFF_TXLVL, 32'h5EF); held <= 13'h5EF;
		@(posedge clk); #1 chk("full0", sok, 0);
		whole <= 1'b1; @(posedge clk); #1 chk("full1", sok, 1);
		snd <= 1'b1; emp <= 1'b1; whole <= 1'b0;
		for (int i = 0; i < 20 && bcrc !== 1'b1; i++)
		begin
			@(posedge clk) #1;
		end
		chk("badcrc", bcrc, 1);
		rdm(NHP_OFF_MEDIA, 1); chk("active", v, 1);
		snd <= 1'b0; emp <= 1'b0; att(0, 0);
		rdm(NHP_OFF_TXRES, 32'h10); chk("starve", v, 32'h10);
		wr(NHP_OFF_TXRES, 0); wr(NHP_OFF_CMD, 2);
		#1 chk("txrst", trst, 1);
		net.send(12); repeat (2) @(posedge clk);
		rdm(NHP_OFF_CAUSE, 2); chk("rxdone", v, 2);
		rdm(NHP_OFF_RXTOP, 32'h1FFF); chk("len", v, 8);
		rdm(NHP_OFF_RXFLT, 1); chk("runt", v, 1);
		rdm(NHP_OFF_WIN, 32'hFFFFFFFF); chk("win", v, 32'h13121110);
		rdm(NHP_OFF_RXTOP, 32'h1FFF); chk("left", v, 4);
		wr(NHP_OFF_MAC, 2); net.send(12); repeat (2) @(posedge clk);
		wr(NHP_OFF_CMD, 4); rdm(NHP_OFF_CAUSE, 2); chk("next", v, 2);
		rdm(NHP_OFF_RXTOP, 32'h1FFF); chk("fcs", v, 12);
		wr(NHP_OFF_DPTR, 32'h100); wr(NHP_OFF_DCNT, 4); wr(NHP_OFF_CMD, 8);
		for (int i = 0; i < 20 && dv !== 1'b1; i++)
		begin
			@(posedge clk) #1;
		end
		chk("dvalid", dv, 1);
		#1 chk("daddr", da, 32'h100);
		chk("ddata", dd, 8'h10);
		repeat (20) @(posedge clk);
		rdm(NHP_OFF_DSTA, 1); chk("dmadone", v, 1);
		wr(NHP_OFF_CMD, 4); net.send(1519); repeat (2) @(posedge clk);
		rdm(NHP_OFF_RXFLT, 2); chk("long", v, 2);
		wr(NHP_OFF_CMD, 4); rdm(NHP_OFF_CAUSE, 2); chk("undone", v, 0);
		wr(NHP_OFF_MAC, 3); crcb <= 1'b1;
		net.send(1519); repeat (2) @(posedge clk);
		rdm(NHP_OFF_RXFLT, 6); chk("big", v, 4);
		summarize();
	end
endmodule : tb_nhp_host_port
`default_nettype wire
